// >>> hdl/hss_fine_pwm.sv
`timescale 1ns/1ns
module hss_fine_pwm
	import hss_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic en,
	input wire logic [7:0] duty,
	input wire logic [7:0] period,
	output logic pulse_q
);
	typedef struct packed {
		logic [7:0] cnt;
		logic pulse;
	} hss_pwm_t;
	hss_pwm_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		// Period follows the span so duty is the raw remainder, no divider
		if (s_q.cnt >= period - 8'h01) begin
			s_d.cnt = 8'h00;
		end else begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
		s_d.pulse = en && (s_q.cnt < duty); // R4
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign pulse_q = s_q.pulse;
endmodule : hss_fine_pwm

// >>> hdl/hss_seq.sv
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module hss_seq
	import hss_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYC,
	parameter int TSTEP_CYCLES = TSTEP_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [4:0] follow_cmd,
	output logic [4:0] stage_out,
	output logic [4:0] ext_stage_out,
	output logic fine_step_terminal_pos,
	output logic [6:0] indicators
);
	typedef struct packed {
		hss_state_t st;
		logic [12:0] cfg;
		logic pwr;
		logic lead;
		logic [8:0] dem;
		logic [3:0] cur;
		logic [27:0] tick;
		logic [6:0] secs;
		logic blink;
		logic wpend;
		logic [3:0] wadr;
		logic [31:0] rdata;
		logic [4:0] so;
		logic [4:0] xo;
		logic [6:0] ind;
	} hss_state_s_t;
	hss_state_s_t s_q, s_d;

	logic [9:0] therm;
	logic [3:0] cnt;
	logic [6:0] dly;
	logic volt;
	logic range_err;
	logic rev;
	logic [7:0] lo;
	logic [7:0] span;
	logic [7:0] off;
	logic [11:0] prod;
	logic [11:0] quo;
	logic [3:0] tgt;
	logic [7:0] rem;
	logic fine_en;
	logic sec_end;
	logic [3:0] cfg_cnt;
	logic [3:0] aidx;

	// One bit per stage, so stage i is lit only while all below it are
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_therm
			assign therm[gi] = (s_q.cur > 4'(gi)); // R1
		end
	endgenerate

	assign cfg_cnt = s_q.cfg[B_CNT +: 4];
	assign aidx = haddr[5:2];
	always_comb begin
		// Follower ignores its own stage dial
		if (!s_q.lead) begin
			cnt = UNIT_STAGES; // R5
		end else if (cfg_cnt == 4'h0) begin
			cnt = 4'h1; // R12
		end else if (cfg_cnt > MAX_STAGES) begin
			cnt = MAX_STAGES; // R12
		end else begin
			cnt = cfg_cnt;
		end
		dly = (s_q.cfg[B_DLY] ? DLY_W0 : 7'h00) + (s_q.cfg[B_DLY + 1] ? DLY_W1 : 7'h00)
			+ (s_q.cfg[B_DLY + 2] ? DLY_W2 : 7'h00) + (s_q.cfg[B_DLY + 3] ? DLY_W3 : 7'h00);
		if (s_q.cfg[B_DLY +: 4] == 4'h0) begin
			dly = DLY_NONE; // R10
		end
		volt = s_q.cfg[B_VOLT] || s_q.cfg[B_THERMOSTAT_INPUT_MODE]; // R6 R7
		rev = s_q.dem[B_REV];
		lo = volt ? 8'h00 : BASE_I;
		span = volt ? SPAN_V : SPAN_I;
		if (volt) begin
			range_err = rev || (s_q.dem[7:0] > HI_V); // R11
		end else begin
			range_err = rev || (s_q.dem[7:0] < LO_I) || (s_q.dem[7:0] > HI_I); // R11
		end
		off = (s_q.dem[7:0] > lo) ? s_q.dem[7:0] - lo : 8'h00;
		if (off > span) begin
			off = span;
		end
		if (rev) begin
			off = 8'h00;
		end
		prod = {4'h0, off} * {8'h00, cnt}; // R19
		quo = prod / {4'h0, span};
		tgt = quo[3:0];
		rem = 8'(prod - quo * {4'h0, span});
		// Fine step only while settled between two stage points
		fine_en = (s_q.st == ST_CTRL) && s_q.lead && s_q.cfg[B_FINE_STEP_OUTPUT_ENABLE]
			&& (s_q.cur == tgt) && (tgt < cnt); // R8 R4
	end

	assign sec_end = (s_q.tick == 28'(SEC_CYCLES - 1));

	always_comb begin
		s_d = s_q;
		// Zero wait state slave; read data prepared in address phase
		s_d.wpend = 1'b0;
		if (s_q.wpend) begin
			case (s_q.wadr)
				A_CFG: s_d.cfg = hwdata[12:0];
				A_PWR: s_d.pwr = hwdata[0];
				A_DEM: s_d.dem = hwdata[8:0];
				default: s_d.wpend = 1'b0;
			endcase
		end
		if (hsel && htrans[1] && hready) begin
			s_d.wpend = hwrite;
			s_d.wadr = aidx;
			case (aidx)
				A_CFG: s_d.rdata = {19'h0, s_q.cfg};
				A_PWR: s_d.rdata = {31'h0, s_q.pwr};
				A_DEM: s_d.rdata = {23'h0, s_q.dem};
				A_STAT: s_d.rdata = {17'h0, s_q.st, range_err, s_q.ind, s_q.cur};
				default: s_d.rdata = 32'h0;
			endcase
		end
		s_d.tick = s_q.tick + 28'h1;
		case (s_q.st)
			ST_OFF: begin
				s_d.cur = 4'h0;
				s_d.tick = 28'h0;
				s_d.secs = 7'h0;
				s_d.blink = 1'b0;
				// Role and mode caught only at power-up; later edits wait for next cycle
				if (s_q.pwr) begin
					s_d.lead = s_q.cfg[B_LEAD]; // R5
					// Follower ignores its own mode switch and tracks the leader
					if (!s_q.cfg[B_LEAD]) begin
						s_d.st = ST_FOL; // R5
					end else if (!s_q.cfg[B_CTRL]) begin
						s_d.st = ST_TUP; // R9
					end else begin
						s_d.st = ST_CTRL; // R9
					end
				end
			end
			ST_TUP: begin
				if (s_q.tick == 28'(TSTEP_CYCLES - 1)) begin
					s_d.tick = 28'h0;
					if (s_q.cur < cnt) begin
						s_d.cur = s_q.cur + 4'h1; // R16
					end else begin
						s_d.st = ST_TDN; // R16
					end
				end
			end
			ST_TDN: begin
				if (s_q.tick == 28'(TSTEP_CYCLES - 1)) begin
					s_d.tick = 28'h0;
					if (s_q.cur != 4'h0) begin
						s_d.cur = s_q.cur - 4'h1; // R16
					end else begin
						s_d.st = ST_TRES; // R17
					end
				end
			end
			ST_TRES: begin
				if (s_q.tick == 28'(BLINK_CYCLES - 1)) begin
					s_d.tick = 28'h0;
					s_d.blink = !s_q.blink; // R17
				end
			end
			ST_CTRL: begin
				if (sec_end) begin
					s_d.tick = 28'h0;
					if (s_q.secs != 7'h7F) begin
						s_d.secs = s_q.secs + 7'h1;
					end
				end
				if (s_q.secs >= dly && s_q.cur != tgt) begin
					s_d.cur = (s_q.cur < tgt) ? s_q.cur + 4'h1 : s_q.cur - 4'h1; // R19 R1
					s_d.tick = 28'h0; // R20
					s_d.secs = 7'h0; // R20
				end
			end
			ST_FOL: begin
				s_d.tick = 28'h0;
			end
			default: s_d.st = ST_OFF;
		endcase
		if (!s_q.pwr) begin
			s_d.st = ST_OFF;
		end
		// Outputs lag the stage count by one cycle to stay on flops
		if (s_q.st == ST_FOL) begin
			s_d.so = follow_cmd; // R5
			s_d.xo = 5'h00;
		end else begin
			s_d.so = therm[4:0]; // R2
			s_d.xo = s_q.lead ? therm[9:5] : 5'h00; // R3
		end
		case (s_q.st)
			ST_TUP, ST_TDN: s_d.ind = s_q.lead ? IND_TEST_LEAD : IND_TEST_FOL; // R15
			ST_TRES: begin
				s_d.ind = IND_SUP; // R17
				if (rev) begin
					s_d.ind[I_PWR] = s_q.blink; // R18
				end else if (range_err) begin
					s_d.ind[I_ERR] = s_q.blink; // R18
				end else begin
					s_d.ind[I_RUN] = s_q.blink; // R18
				end
			end
			ST_CTRL, ST_FOL: begin
				s_d.ind = IND_SUP;
				s_d.ind[I_PWR] = 1'b1;
				s_d.ind[I_RUN] = 1'b1;
				s_d.ind[I_ERR] = s_q.lead && range_err; // R11
				s_d.ind[I_FINE] = s_q.lead && s_q.cfg[B_FINE_STEP_OUTPUT_ENABLE];
				s_d.ind[I_ROLE] = !s_q.lead;
			end
			default: s_d.ind = 7'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.cfg <= CFG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	hss_fine_pwm u_pwm (
		.hclk(hclk),
		.hresetn(hresetn),
		.en(fine_en),
		.duty(rem),
		.period(span),
		.pulse_q(fine_step_terminal_pos)
	);

	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign stage_out = s_q.so;
	assign ext_stage_out = s_q.xo;
	assign indicators = s_q.ind;

	property p_lifo;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_CTRL && s_d.st == ST_CTRL && s_d.cur != s_q.cur)
			|-> (s_d.cur == s_q.cur + 4'h1) || (s_d.cur == s_q.cur - 4'h1);
	endproperty
	a_lifo: assert property (p_lifo) else $error("stage moved by more than one"); // R1

	property p_cap;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st != ST_OFF) |-> (s_q.cur <= cnt);
	endproperty
	a_cap: assert property (p_cap) else $error("stage count above limit"); // R12

	property p_split;
		@(posedge hclk) disable iff (!hresetn)
		(ext_stage_out != 5'h00) |-> (stage_out == 5'h1F);
	endproperty
	a_split: assert property (p_split) else $error("follower stage before local full"); // R3

	property p_fine_step_output_enable;
		@(posedge hclk) disable iff (!hresetn)
		(!s_q.cfg[B_FINE_STEP_OUTPUT_ENABLE]) ##1 (!s_q.cfg[B_FINE_STEP_OUTPUT_ENABLE]) |-> !fine_step_terminal_pos;
	endproperty
	a_fine_step_output_enable: assert property (p_fine_step_output_enable) else $error("fine step while disabled"); // R8

	property p_delay;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_CTRL && s_d.st == ST_CTRL && s_d.cur != s_q.cur) |-> (s_q.secs >= dly);
	endproperty
	a_delay: assert property (p_delay) else $error("stage change before delay"); // R10

	property p_restart;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_CTRL && s_d.cur != s_q.cur) |=> (s_q.tick == 28'h0 && s_q.secs == 7'h0);
	endproperty
	a_restart: assert property (p_restart) else $error("delay timer not restarted"); // R20

	property p_err;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_CTRL && range_err && s_q.lead) |=> indicators[I_ERR];
	endproperty
	a_err: assert property (p_err) else $error("range error not shown"); // R11

	property p_test_ind;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_TUP && s_q.lead) |=> (indicators == IND_TEST_LEAD);
	endproperty
	a_test_ind: assert property (p_test_ind) else $error("test indicator set wrong"); // R15

	property p_result;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.st == ST_TRES && $past(s_q.st) == ST_TRES)
			|-> (indicators[I_SUP] && (indicators & 7'h78) == 7'h10 && $countones(indicators) <= 2);
	endproperty
	a_result: assert property (p_result) else $error("result shows wrong lights"); // R17

	c_result: cover property (@(posedge hclk) disable iff (!hresetn) s_q.st == ST_TRES);
	c_full: cover property (@(posedge hclk) disable iff (!hresetn) s_q.cur == MAX_STAGES);
	c_fine: cover property (@(posedge hclk) disable iff (!hresetn) fine_step_terminal_pos);
endmodule : hss_seq

// >>> shared/hss_pkg.sv
// Operation
// (R1) Stages go off in reverse order of on
// (R2) Five stage outputs plus one pulsed fine step
// (R3) Leader drives follower stages six to ten
// (R4) Fine step spans one stage between steps
// (R5) Role select; follower obeys leader only
// (R6) Input type: current loop or voltage
// (R7) Thermostat mode uses the voltage input
// (R8) Fine step output enabled by switch
// (R9) Test or control mode sampled at power
// (R10) Delay is weighted switch sum, else 1 s
// (R11) Out of range lights error, staging continues
// (R12) Stage count one to ten, never exceeded
// (R13) Follower present needs count above five
// (R14) Follower fine step and demand wiring outside
// (R15) Test mode lights fixed indicator set
// (R16) Test cycles stages up then down
// (R17) Then only supply lit, one blinks
// (R18) Blink power, error or run by check
// (R19) Demand linear in input, changes spaced by delay
// (R20) Delay counter restarts after each change
package hss_pkg;
	localparam logic [3:0] A_CFG = 4'h0;
	localparam logic [3:0] A_PWR = 4'h1;
	localparam logic [3:0] A_DEM = 4'h2;
	localparam logic [3:0] A_STAT = 4'h3;
	localparam logic [12:0] CFG_RST = 13'h0A11;
	localparam int B_LEAD = 0;
	localparam int B_VOLT = 1;
	localparam int B_THERMOSTAT_INPUT_MODE = 2;
	localparam int B_FINE_STEP_OUTPUT_ENABLE = 3;
	localparam int B_CTRL = 4;
	localparam int B_DLY = 5;
	localparam int B_CNT = 9;
	localparam int B_REV = 8;
	localparam int I_PWR = 0;
	localparam int I_ERR = 1;
	localparam int I_RUN = 2;
	localparam int I_FLT = 3;
	localparam int I_SUP = 4;
	localparam int I_FINE = 5;
	localparam int I_ROLE = 6;
	localparam logic [6:0] IND_TEST_LEAD = 7'h7F;
	localparam logic [6:0] IND_TEST_FOL = 7'h55;
	localparam logic [6:0] IND_SUP = 7'h10;
	localparam logic [3:0] MAX_STAGES = 4'hA;
	localparam logic [3:0] UNIT_STAGES = 4'h5;
	localparam logic [6:0] DLY_W0 = 7'h05;
	localparam logic [6:0] DLY_W1 = 7'h0A;
	localparam logic [6:0] DLY_W2 = 7'h14;
	localparam logic [6:0] DLY_W3 = 7'h28;
	localparam logic [6:0] DLY_NONE = 7'h01;
	// Demand codes are in tenths of a mA or a volt
	localparam logic [7:0] LO_I = 8'h1E;
	localparam logic [7:0] HI_I = 8'hD2;
	localparam logic [7:0] HI_V = 8'h69;
	localparam logic [7:0] BASE_I = 8'h28;
	localparam logic [7:0] SPAN_I = 8'hA0;
	localparam logic [7:0] SPAN_V = 8'h64;
	localparam int CLK_NS = 4;
	localparam int SEC_NS = 1000000000;
	localparam int TSTEP_MS = 500;
	localparam int BLINK_MS = 250;
	localparam int SEC_CYC = SEC_NS / CLK_NS;
	localparam int TSTEP_CYC = TSTEP_MS * (1000000 / CLK_NS);
	localparam int BLINK_CYC = BLINK_MS * (1000000 / CLK_NS);
	typedef enum logic [2:0] {ST_OFF, ST_TUP, ST_TDN, ST_TRES, ST_CTRL, ST_FOL} hss_state_t;
endpackage : hss_pkg

// >>> verif/hss_load_model.sv
`timescale 1ns/1ns
module hss_load_model (
	input wire logic hclk,
	input wire logic clr,
	input wire logic [4:0] stage_out,
	input wire logic [4:0] ext_stage_out,
	input wire logic fine_step_terminal_pos,
	output logic [9:0] loads,
	output int n_on,
	output logic fine_seen
);
	// Follower bank hangs off the upper five outputs
	assign loads = {ext_stage_out, stage_out};
	always_comb begin
		n_on = 0;
		for (int i = 0; i < 10; i++) begin
			n_on += loads[i];
		end
	end
	// Power controller is fed by the leader pulse only
	always_ff @(posedge hclk) begin
		fine_seen <= !clr && (fine_seen || fine_step_terminal_pos);
	end
endmodule : hss_load_model

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top import hss_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, fine, clr, fine_seen, ctrl_on;
	logic [31:0] haddr, hwdata, hrdata, r, code;
	logic [1:0] htrans;
	logic [4:0] follow_cmd, so, eso;
	logic [6:0] ind, o;
	logic [9:0] loads, last;
	int n_on, last_n, gap, err_count, num_checks, cnt, dly, tgt;
	logic [31:0] seed = 32'h0000003E;
	logic [31:0] tab [5] = '{32'h0, 32'h37, 32'h6A, 32'h164, 32'h0};
	assign hready = hreadyout;
	hss_seq #(.SEC_CYCLES(20), .TSTEP_CYCLES(4), .BLINK_CYCLES(4)) i_hss_seq (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .follow_cmd(follow_cmd), .stage_out(so),
		.ext_stage_out(eso), .fine_step_terminal_pos(fine), .indicators(ind));
	hss_load_model i_hss_load_model (.hclk(hclk), .clr(clr), .stage_out(so),
		.ext_stage_out(eso), .fine_step_terminal_pos(fine), .loads(loads), .n_on(n_on),
		.fine_seen(fine_seen));
	task close_out();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [9:0] therm(input int n);
		return 10'((1 << n) - 1);
	endfunction : therm
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task rdy();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			err_count++;
			close_out();
		end
	endtask : rdy
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask : bus
	task waitl(input logic [9:0] v);
		for (int i = 0; i < 200 && loads !== v; i++) @(posedge hclk);
		chk("reach", loads, v);
		if (loads !== v) close_out();
	endtask : waitl
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// Bounded run, a hang still reaches the verdict
	initial begin
		#360000;
		err_count++;
		close_out();
	end
	// Every stage change is checked as it happens
	always @(posedge hclk) begin
		if (hresetn && loads !== last) begin
			chk("lifo", loads, therm(n_on));
			chk("max", 32'(n_on <= cnt), 1);
			if (ctrl_on) chk("step", 32'(n_on == last_n + 1 || n_on + 1 == last_n), 1);
			if (ctrl_on) chk("gap", 32'(gap >= dly), 1);
			gap = 0;
		end else gap++;
		last = loads;
		last_n = n_on;
	end
	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, follow_cmd, clr, ctrl_on} = '0;
		last = '0;
		cnt = 10;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 32'h0, 0);
		chk("cfg_rst", r, 32'h0A11);
		bus(0, 32'h4, 0);
		chk("pwr_rst", r, 0);
		bus(0, 32'h10, 0);
		chk("unmapped", r, 0);
		$display("test reset done");
		cnt = 3;
		// Second pass with reversed input must blink power instead of run
		for (int t = 0; t < 2; t++) begin
			bus(1, 32'h8, t ? 32'h164 : 32'h64);
			bus(1, 32'h0, 32'h601);
			bus(1, 32'h4, 1);
			repeat (3) @(posedge hclk);
			chk("ind_test", 32'(ind), 32'(IND_TEST_LEAD));
			waitl(therm(3));
			waitl(0);
			repeat (4) @(posedge hclk);
			o = '0;
			repeat (16) begin
				@(posedge hclk);
				o |= ind;
			end
			chk("result", 32'(o), t ? 32'h11 : 32'h14);
			bus(1, 32'h4, 0);
		end
		$display("test self_test done");
		cnt = 10;
		dly = 100;
		bus(1, 32'h0, 32'h143B);
		ctrl_on = 1'b1;
		gap = 0;
		bus(1, 32'h4, 1);
		for (int k = 0; k < 5; k++) begin
			code = (k == 0) ? xs() % 101 : tab[k];
			bus(1, 32'h8, code);
			// Reversed input gives no demand; span is 10.0 V in tenths
			tgt = code[8] ? 0 : (code % 256) * cnt / 100;
			tgt = (tgt > cnt) ? cnt : tgt;
			repeat (2) @(posedge hclk);
			clr <= 1'b1;
			@(posedge hclk);
			clr <= 1'b0;
			repeat (1100) @(posedge hclk);
			chk("stages", loads, therm(tgt));
			chk("err", 32'(ind[I_ERR]), 32'(code[8] || code[7:0] > 8'h69));
			if (k > 0) chk("fine", 32'(fine_seen), 32'(!code[8] && tgt < cnt && (code % 256) * cnt % 100 != 0));
		end
		ctrl_on = 1'b0;
		bus(1, 32'h4, 0);
		$display("test control done");
		// Follower must ignore the test setting
		bus(1, 32'h0, 0);
		bus(1, 32'h4, 1);
		follow_cmd <= 5'h07;
		repeat (5) @(posedge hclk);
		chk("follow", 32'(so), 32'h07);
		chk("fol_ext", 32'(eso), 0);
		chk("fol_ind", 32'(ind), 32'h55);
		$display("test follower done");
		close_out();
	end
endmodule : tb_top
